// [rtl/sac_top.sv]
`timescale 1ns/100ps
`include "sac_consts.svh"

module sac_top
(
   input  logic                     clk,             // bus clock
   input  logic                     resetn,          // async reset
   input  logic                     osc_clk,         // oscillator clock level
   input  logic                     stop_mode,       // cpu in stop mode
   input  logic                     scr_wr,          // status/control write
   input  logic [4:0]               wr_chan,         // channel select field
   input  logic                     wr_ien,          // interrupt enable
   input  logic                     wr_cont,         // continuous mode bit
   input  logic                     clkctl_wr,       // clock control write
   input  logic                     wr_src_sel,      // 1 = oscillator clock
   input  logic [2:0]               wr_div,          // clock divide field
   input  logic [1:0]               wr_fmt,          // justify select hi,lo
   input  logic                     rd_high,         // result high read
   input  logic                     rd_low,          // result low read
   input  logic                     cmp_in,          // input >= trial code
   input  logic [5:0]               port_latch,      // port output latch
   input  logic [5:0]               port_dir,        // port direction
   input  logic [5:0]               pin_in,          // pin levels
   output logic [4:0]               chan_sel_q,      // analog mux select
   output logic                     pwr_off_q,       // converter powered off
   output logic                     sample_q,        // sampling phase
   output logic [9:0]               trial_code_q,    // sar trial code
   output logic                     busy_q,          // conversion running
   output logic [7:0]               result_high_q,   // result high register
   output logic [7:0]               result_low_q,    // result low register
   output logic                     done_flag_q,     // conversion done flag
   output logic                     irq_q,           // interrupt request
   output logic [5:0]               pin_take_q,      // pin owned by converter
   output logic [5:0]               pin_oe_q,        // pin output enable
   output logic [5:0]               pin_out_q,       // pin output level
   output logic [5:0]               port_rd_q        // port read value
);

   ////////////////////////////////////////////////////////////////////////////
   sac_pkg::sac_regs_t    q;
   sac_pkg::sac_regs_t    d;
   logic                  src_pulse;
   logic                  tick;
   logic                  conv_done;
   logic [9:0]            conv_res;
   logic [9:0]            sar_new;
   logic [2:0]            div_eff;
   logic [3:0]            ratio_m1;
   logic                  start;

   always_comb
   begin
      d         = q;
      conv_done = 1'b0;
      conv_res  = q.sar;
      sar_new   = q.sar;
      tick      = 1'b0;
      // source select then prescale, both free running
      src_pulse  = q.src_sel ? (osc_clk & ~q.osc_prev) : 1'b1;
      d.osc_prev = osc_clk;
      div_eff    = (q.div > `SAC_DIV_MAX) ? `SAC_DIV_MAX : q.div;
      ratio_m1   = ~(4'hF << div_eff);
      if (src_pulse)
      begin
         if (q.div_cnt >= ratio_m1)
         begin
            d.div_cnt = 4'h0;
            tick      = 1'b1;
         end
         else
         begin
            d.div_cnt = q.div_cnt + 4'h1;
         end
      end

      ////////////////////////////////////////////////////////////////////////
      case (q.state)
         sac_pkg::SAC_IDLE:
         begin
            // resume after stop if still armed
            if (q.run && !stop_mode)
               d.state = sac_pkg::SAC_ALIGN;
         end
         sac_pkg::SAC_ALIGN:
         begin
            // partial first cycle, counted as the first
            if (tick)
            begin
               d.state  = sac_pkg::SAC_SAMPLE;
               d.cnt    = 5'h01;
               d.sample = 1'b1;
            end
         end
         sac_pkg::SAC_SAMPLE:
         begin
            if (tick)
            begin
               d.cnt = q.cnt + 5'h01;
               if (d.cnt == `SAC_SAMPLE_TICKS)
               begin
                  d.state  = sac_pkg::SAC_TRIAL;
                  d.sample = 1'b0;
                  d.mask   = `SAC_TRIAL_FIRST;
                  d.sar    = `SAC_TRIAL_FIRST;
               end
            end
         end
         sac_pkg::SAC_TRIAL:
         begin
            if (tick)
            begin
               // comparator decides the bit under trial; above vref saturates
               sar_new = (cmp_in ? q.sar : (q.sar & ~q.mask)) | (q.mask >> 1);
               d.sar   = sar_new;
               d.mask  = q.mask >> 1;
               d.cnt   = q.cnt + 5'h01;
               if (d.cnt == `SAC_CONV_TICKS)
               begin
                  conv_done = 1'b1;
                  conv_res  = sar_new;
                  if (q.cont)
                  begin
                     d.state = sac_pkg::SAC_ALIGN;
                  end
                  else
                  begin
                     d.state = sac_pkg::SAC_IDLE;
                     d.run   = 1'b0;
                  end
               end
            end
         end
         default:
         begin
            d.state = sac_pkg::SAC_IDLE;
         end
      endcase

      ////////////////////////////////////////////////////////////////////////
      // result store; outside truncated format, interlock blocks new data once high is read
      if (conv_done && (!q.locked || q.fmt == `SAC_FMT_TRUNC))
      begin
         case (q.fmt)
            `SAC_FMT_RIGHT:
            begin
               d.res_hi = {6'h00, conv_res[9:8]};
               d.res_lo = conv_res[7:0];
            end
            `SAC_FMT_LEFT:
            begin
               d.res_hi = conv_res[9:2];
               d.res_lo = {conv_res[1:0], 6'h00};
            end
            `SAC_FMT_SIGN:
            begin
               d.res_hi = {~conv_res[9], conv_res[8:2]};
               d.res_lo = {conv_res[1:0], 6'h00};
            end
            default:
            begin
               d.res_hi = 8'h00;
               d.res_lo = conv_res[9:2];
            end
         endcase
      end
      if (rd_high && q.fmt != `SAC_FMT_TRUNC)
         d.locked = 1'b1;
      if (rd_low || q.fmt == `SAC_FMT_TRUNC)
         d.locked = 1'b0;

      ////////////////////////////////////////////////////////////////////////
      // register writes; a status/control write aborts, and restarts unless the channel is off
      start = 1'b0;
      if (clkctl_wr)
      begin
         d.src_sel = wr_src_sel;
         d.div     = wr_div;
         d.fmt     = wr_fmt;
         d.done    = 1'b0;
      end
      if (scr_wr)
      begin
         d.chan   = wr_chan;
         d.ien    = wr_ien;
         d.cont   = wr_cont;
         d.done   = 1'b0;
         d.irq    = 1'b0;
         d.sample = 1'b0;
         start    = (wr_chan != `SAC_CH_OFF);
         d.run    = start;
         d.state  = (start && !stop_mode) ? sac_pkg::SAC_ALIGN
                                          : sac_pkg::SAC_IDLE;
      end
      if (rd_low)
         d.done = 1'b0;
      if (rd_low || rd_high)
         d.irq = 1'b0;
      // hardware set wins over any clear in the same cycle
      if (conv_done && !d.ien)
         d.done = 1'b1;
      // the request also serves as the wake-up source in wait mode
      if (conv_done && d.ien)
         d.irq = 1'b1;

      // stop mode overrides the state and sampling; run stays armed for resume
      if (stop_mode)
      begin
         d.state  = sac_pkg::SAC_IDLE;
         d.sample = 1'b0;
      end
      d.busy    = (d.state != sac_pkg::SAC_IDLE);
      d.pwr_off = (d.chan == `SAC_CH_OFF);

      ////////////////////////////////////////////////////////////////////////
      // pin ownership; direction reaches the output enable of untaken pins only but steers the port read of every pin, latch drives every pin
      d.pin_take = (d.chan <= `SAC_CH_PIN_LAST) ? (6'h01 << d.chan[2:0]) : 6'h00;
      d.pin_oe   = port_dir & ~d.pin_take;
      d.pin_out  = port_latch;
      d.port_rd  = (port_dir & port_latch) | (~port_dir & pin_in);
   end

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
         q <= '0;
      else
         q <= d;
   end

   assign chan_sel_q    = q.chan;
   assign pwr_off_q     = q.pwr_off;
   assign sample_q      = q.sample;
   assign trial_code_q  = q.sar;
   assign busy_q        = q.busy;
   assign result_high_q = q.res_hi;
   assign result_low_q  = q.res_lo;
   assign done_flag_q   = q.done;
   assign irq_q         = q.irq;
   assign pin_take_q    = q.pin_take;
   assign pin_oe_q      = q.pin_oe;
   assign pin_out_q     = q.pin_out;
   assign port_rd_q     = q.port_rd;

   ////////////////////////////////////////////////////////////////////////////
   // checking helpers: ticks seen since the conversion was armed
   logic [4:0] chk_ticks_q;

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
         chk_ticks_q <= 5'h00;
      else if (q.state == sac_pkg::SAC_IDLE ||
               (d.state == sac_pkg::SAC_ALIGN && q.state != sac_pkg::SAC_ALIGN))
         chk_ticks_q <= 5'h00;
      else if (tick)
         chk_ticks_q <= chk_ticks_q + 5'h01;
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);

   AST_CONV_LEN: assert property (conv_done |-> chk_ticks_q == (`SAC_CONV_TICKS - 5'h01))
      else $error("conversion did not take sixteen converter ticks");
   AST_START: assert property (scr_wr && !stop_mode && wr_chan != `SAC_CH_OFF
      |=> q.state == sac_pkg::SAC_ALIGN && (!done_flag_q || $past(conv_done)))
      else $error("control write did not restart the conversion");
   AST_STOP_ABORT: assert property (stop_mode |=> !busy_q && !sample_q)
      else $error("stop mode left the converter active");
   AST_DONE_SET: assert property (conv_done && !d.ien
      |=> done_flag_q ##0 !irq_q || $past(irq_q))
      else $error("done flag not set after conversion");
   AST_IEN_ZERO: assert property (q.ien |-> !done_flag_q)
      else $error("done flag visible with interrupt enabled");
   AST_IRQ_SET: assert property (conv_done && q.ien && !scr_wr
      |=> irq_q [*1] ##0 !done_flag_q)
      else $error("interrupt not raised after conversion");
   AST_TRUNC: assert property (conv_done && q.fmt == `SAC_FMT_TRUNC
      |=> result_low_q == $past(conv_res[9:2]) && result_high_q == 8'h00)
      else $error("truncated result misplaced");
   AST_SIGN: assert property (conv_done && q.fmt == `SAC_FMT_SIGN && !q.locked
      |=> result_high_q[7] == ~$past(conv_res[9]))
      else $error("signed format msb not inverted");
   AST_LOCK: assert property (q.locked && q.fmt != `SAC_FMT_TRUNC
      |=> $stable(result_low_q))
      else $error("result overwritten while interlocked");
   AST_PIN_TAKE: assert property (q.chan <= `SAC_CH_PIN_LAST && !scr_wr
      |=> pin_take_q[$past(q.chan[2:0])] && !pin_oe_q[$past(q.chan[2:0])])
      else $error("selected pin not taken by converter");
   AST_PORT_RD: assert property (1'b1 |=> port_rd_q
      == ($past(port_dir) & $past(port_latch) | ~$past(port_dir) & $past(pin_in)))
      else $error("port read value wrong");
   AST_CONT: assert property (conv_done && q.cont && !scr_wr && !stop_mode
      |=> q.state == sac_pkg::SAC_ALIGN)
      else $error("continuous mode did not rearm");

   COV_SINGLE: cover property (conv_done && !q.cont ##1 done_flag_q);
   COV_CONT:   cover property (conv_done && q.cont ##[1:400] conv_done);
   COV_STOP:   cover property (q.state == sac_pkg::SAC_TRIAL && stop_mode);
   COV_IRQ:    cover property (irq_q ##1 rd_low ##1 !irq_q);

endmodule

// [rtl/sac_consts.svh]
`ifndef SAC_CONSTS_SVH
`define SAC_CONSTS_SVH

// result and pin geometry
`define SAC_RES_W        10
`define SAC_NUM_PINS     6
`define SAC_FULL_SCALE   10'h3FF
`define SAC_ZERO_SCALE   10'h000

// channel select codes
`define SAC_CH_PIN_LAST  5'h05
`define SAC_CH_BANDGAP   5'h06
`define SAC_CH_VREF_HIGH 5'h1D
`define SAC_CH_VREF_LOW  5'h1E
`define SAC_CH_OFF       5'h1F

// justify select encodings, {justify_select_hi, justify_select_lo}
`define SAC_FMT_TRUNC    2'h0
`define SAC_FMT_RIGHT    2'h1
`define SAC_FMT_LEFT     2'h2
`define SAC_FMT_SIGN     2'h3

// converter timing in divided converter clock ticks, divider limit and first trial code
`define SAC_SAMPLE_TICKS 5'h06
`define SAC_CONV_TICKS   5'h10
`define SAC_DIV_MAX      3'h4
`define SAC_TRIAL_FIRST  10'h200

`endif

// [rtl/sac_pkg.sv]
`include "sac_consts.svh"

package sac_pkg;

   typedef enum logic [1:0] {
      SAC_IDLE   = 2'b00,
      SAC_ALIGN  = 2'b01,
      SAC_SAMPLE = 2'b10,
      SAC_TRIAL  = 2'b11
   } sac_state_t;

   typedef struct packed {
      sac_state_t                  state;
      logic [4:0]                  chan;
      logic                        ien;
      logic                        cont;
      logic                        src_sel;
      logic [2:0]                  div;
      logic [1:0]                  fmt;
      logic                        run;
      logic [3:0]                  div_cnt;
      logic                        osc_prev;
      logic [4:0]                  cnt;
      logic [`SAC_RES_W-1:0]       mask;
      logic [`SAC_RES_W-1:0]       sar;
      logic [7:0]                  res_hi;
      logic [7:0]                  res_lo;
      logic                        locked;
      logic                        done;
      logic                        irq;
      logic                        sample;
      logic                        busy;
      logic                        pwr_off;
      logic [`SAC_NUM_PINS-1:0]    pin_take;
      logic [`SAC_NUM_PINS-1:0]    pin_oe;
      logic [`SAC_NUM_PINS-1:0]    pin_out;
      logic [`SAC_NUM_PINS-1:0]    port_rd;
   } sac_regs_t;

endpackage

// [testbench/sac_cmp_model.sv]
`timescale 1ns/100ps
module sac_cmp_model
#(
   parameter logic [9:0] BG_CODE = 10'h180   // bandgap channel level
)
(
   input  logic       clk,           // bus clock
   input  logic       resetn,        // async reset
   input  logic [4:0] chan_sel_q,    // mux select
   input  logic       pwr_off_q,     // core off
   input  logic       sample_q,      // sampling phase
   input  logic [9:0] trial_code_q,  // trial code
   input  logic [9:0] ext_code,      // level on selected pin
   output logic       cmp_in         // input >= trial
);
   logic [9:0] vin;
   logic [9:0] held_q;
   logic       flip_q;

   always_comb
      case (chan_sel_q)
         5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05: vin = ext_code;
         5'h06: vin = BG_CODE;
         5'h1D: vin = 10'h3FF;
         5'h1E: vin = 10'h000;
         default: vin = 10'h155;
      endcase

   always_ff @(posedge clk or negedge resetn)
      if (!resetn)
      begin
         held_q <= 10'h000;
         flip_q <= 1'b0;
      end
      else
      begin
         flip_q <= ~flip_q;
         if (sample_q)
            held_q <= vin;
      end

   // a powered-off core gives no steady answer
   assign cmp_in = pwr_off_q ? flip_q : (held_q >= trial_code_q);
endmodule

// [testbench/sac_top_tb.sv]
`timescale 1ns/100ps
module sac_top_tb;
   localparam logic [9:0] BG = 10'h180;
   logic       clk, resetn, osc_clk, stop_mode, scr_wr, wr_ien, wr_cont, clkctl_wr;
   logic       wr_src_sel, rd_high, rd_low, cmp_in, pwr_off_q, sample_q, busy_q;
   logic       done_flag_q, irq_q;
   logic [4:0] wr_chan, chan_sel_q;
   logic [2:0] wr_div;
   logic [1:0] wr_fmt;
   logic [5:0] port_latch, port_dir, pin_in, pin_take_q, pin_oe_q, pin_out_q, port_rd_q;
   logic [9:0] trial_code_q, ext_code;
   logic [7:0] result_high_q, result_low_q;
   int         err_total, checks_done;

   sac_top sac_top_inst (.clk(clk), .resetn(resetn), .osc_clk(osc_clk),
      .stop_mode(stop_mode), .scr_wr(scr_wr), .wr_chan(wr_chan), .wr_ien(wr_ien),
      .wr_cont(wr_cont), .clkctl_wr(clkctl_wr), .wr_src_sel(wr_src_sel), .wr_div(wr_div),
      .wr_fmt(wr_fmt), .rd_high(rd_high), .rd_low(rd_low), .cmp_in(cmp_in),
      .port_latch(port_latch), .port_dir(port_dir), .pin_in(pin_in),
      .chan_sel_q(chan_sel_q), .pwr_off_q(pwr_off_q), .sample_q(sample_q),
      .trial_code_q(trial_code_q), .busy_q(busy_q), .result_high_q(result_high_q),
      .result_low_q(result_low_q), .done_flag_q(done_flag_q), .irq_q(irq_q),
      .pin_take_q(pin_take_q), .pin_oe_q(pin_oe_q), .pin_out_q(pin_out_q),
      .port_rd_q(port_rd_q));

   sac_cmp_model #(.BG_CODE(BG)) sac_cmp_model_inst (.clk(clk), .resetn(resetn),
      .chan_sel_q(chan_sel_q), .pwr_off_q(pwr_off_q), .sample_q(sample_q),
      .trial_code_q(trial_code_q), .ext_code(ext_code), .cmp_in(cmp_in));

   ////////////////////////////////////////////////////////////////////////////////
   task automatic close_out();
      $display("err_total=%0d checks_done=%0d", err_total, checks_done);
      if (err_total == 0 && checks_done > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   task automatic chk(input logic [9:0] got, input logic [9:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         err_total++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic chk_rng(input int n, input int lo, input int hi);
      checks_done++;
      if (n < lo || n > hi)
      begin
         err_total++;
         $display("wrong value at %0t: %0d cycles, not %0d..%0d", $time, n, lo, hi);
      end
   endtask

   task automatic wr_scr(input logic [4:0] ch, input logic ien, input logic cont);
      @(posedge clk);
      scr_wr <= 1'b1;
      wr_chan <= ch;
      wr_ien <= ien;
      wr_cont <= cont;
      @(posedge clk);
      scr_wr <= 1'b0;
      #1;
   endtask

   task automatic wr_clk(input logic src, input logic [2:0] dv, input logic [1:0] fmt);
      @(posedge clk);
      clkctl_wr <= 1'b1;
      wr_src_sel <= src;
      wr_div <= dv;
      wr_fmt <= fmt;
      @(posedge clk);
      clkctl_wr <= 1'b0;
      #1;
   endtask

   task automatic rd(input logic hi);
      @(posedge clk);
      rd_high <= hi;
      rd_low <= ~hi;
      @(posedge clk);
      rd_high <= 1'b0;
      rd_low <= 1'b0;
      #1;
   endtask

   // n counts cycles from the write edge to the completion indication
   task automatic wait_end(output int n);
      n = 1;
      while ((done_flag_q | irq_q) !== 1'b1 && n < 600)
      begin
         @(posedge clk);
         #1;
         n++;
      end
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_timing();
      int n;
      logic [2:0] dv [5] = '{3'h0, 3'h1, 3'h4, 3'h7, 3'h1};
      int r [5] = '{1, 2, 16, 16, 4};
      ext_code <= 10'h2A5;
      for (int i = 0; i < 5; i++)
      begin
         wr_clk(i == 4, dv[i], 2'h0);
         wr_scr(5'h02, 1'b0, 1'b0);
         wait_end(n);
         chk_rng(n, 15 * r[i] + 1, 17 * r[i]);
         chk(trial_code_q, 10'h2A5);
         chk({2'h0, result_low_q}, 10'h0A9);
         chk({2'h0, result_high_q}, 10'h000);
      end
   endtask

   task automatic t_formats();
      int n;
      logic [9:0] c = 10'h2A5;
      logic [7:0] eh [4] = '{8'h00, {6'h00, c[9:8]}, c[9:2], {~c[9], c[8:2]}};
      logic [7:0] el [4] = '{c[9:2], c[7:0], {c[1:0], 6'h00}, {c[1:0], 6'h00}};
      for (int f = 0; f < 4; f++)
      begin
         wr_clk(1'b0, 3'h0, 2'(f));
         wr_scr(5'h04, 1'b0, 1'b0);
         wait_end(n);
         chk({2'h0, result_high_q}, {2'h0, eh[f]});
         chk({2'h0, result_low_q}, {2'h0, el[f]});
         rd(1'b1);
         rd(1'b0);
      end
   endtask

   task automatic t_lock();
      int n;
      wr_clk(1'b0, 3'h0, 2'h2);
      wr_scr(5'h1D, 1'b0, 1'b0);
      wait_end(n);
      chk({2'h0, result_high_q}, 10'h0FF);
      rd(1'b1);
      wr_scr(5'h1E, 1'b0, 1'b0);
      wait_end(n);
      chk({2'h0, result_high_q}, 10'h0FF);
      chk({2'h0, result_low_q}, 10'h0C0);
      rd(1'b0);
      chk(done_flag_q, 1'b0);
      wr_scr(5'h1E, 1'b0, 1'b0);
      wait_end(n);
      chk({2'h0, result_high_q}, 10'h000);
   endtask

   task automatic t_irq();
      int n;
      wr_clk(1'b0, 3'h0, 2'h0);
      wr_scr(5'h02, 1'b1, 1'b0);
      wait_end(n);
      chk(irq_q, 1'b1);
      chk(done_flag_q, 1'b0);
      rd(1'b0);
      chk(irq_q, 1'b0);
      wr_scr(5'h02, 1'b1, 1'b0);
      wait_end(n);
      wr_scr(5'h02, 1'b0, 1'b0);
      chk(irq_q, 1'b0);
      wait_end(n);
      chk(done_flag_q, 1'b1);
   endtask

   task automatic t_abort();
      int n;
      wr_scr(5'h1D, 1'b0, 1'b0);
      chk(done_flag_q, 1'b0);
      chk(busy_q, 1'b1);
      @(posedge clk);
      #1;
      chk(sample_q, 1'b1);
      repeat (8) @(posedge clk);
      wr_scr(5'h1E, 1'b0, 1'b0);
      wait_end(n);
      chk_rng(n, 16, 17);
      chk({2'h0, result_low_q}, 10'h000);
   endtask

   task automatic t_cont();
      int n;
      ext_code <= 10'h100;
      wr_scr(5'h00, 1'b0, 1'b1);
      wait_end(n);
      chk({2'h0, result_low_q}, 10'h040);
      ext_code <= 10'h200;
      rd(1'b0);
      wait_end(n);
      chk(done_flag_q, 1'b1);
      rd(1'b0);
      wait_end(n);
      chk({2'h0, result_low_q}, 10'h080);
      wr_scr(5'h00, 1'b0, 1'b0);
      wait_end(n);
      repeat (40) @(posedge clk);
      #1;
      chk(busy_q, 1'b0);
   endtask

   task automatic t_stop();
      int n;
      wr_scr(5'h02, 1'b0, 1'b0);
      repeat (5) @(posedge clk);
      stop_mode <= 1'b1;
      repeat (2) @(posedge clk);
      #1;
      chk(busy_q, 1'b0);
      chk(sample_q, 1'b0);
      repeat (30) @(posedge clk);
      #1;
      chk(done_flag_q, 1'b0);
      @(posedge clk);
      stop_mode <= 1'b0;
      wait_end(n);
      chk(done_flag_q, 1'b1);
   endtask

   task automatic t_pins();
      int n;
      @(posedge clk);
      port_latch <= 6'h22;
      port_dir <= 6'h3C;
      pin_in <= 6'h1D;
      wr_scr(5'h03, 1'b0, 1'b0);
      repeat (2) @(posedge clk);
      #1;
      chk(chan_sel_q, 5'h03);
      chk(pin_take_q, 6'h08);
      chk(pin_oe_q, 6'h34);
      chk(pin_out_q, 6'h22);
      chk(port_rd_q, 6'h21);
      @(posedge clk);
      port_dir <= 6'h0B;
      repeat (2) @(posedge clk);
      #1;
      chk(pin_oe_q, 6'h03);
      chk(port_rd_q, 6'h16);
      wr_scr(5'h1F, 1'b0, 1'b0);
      repeat (2) @(posedge clk);
      #1;
      chk(pwr_off_q, 1'b1);
      chk(busy_q, 1'b0);
      chk(pin_oe_q, 6'h0B);
      wr_scr(5'h06, 1'b0, 1'b0);
      wait_end(n);
      chk(pin_take_q, 6'h00);
      chk({2'h0, result_low_q}, {4'h0, BG[9:4]} << 2 | {8'h00, BG[3:2]});
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // oscillator source pulses every second bus cycle
   always @(posedge clk)
      osc_clk <= ~osc_clk;

   initial
   begin
      #400000;
      err_total++;
      $display("wrong value at %0t: watchdog expired", $time);
      close_out();
   end

   initial
   begin
      {resetn, osc_clk, stop_mode, scr_wr, wr_ien, wr_cont, clkctl_wr} = 7'h00;
      {wr_src_sel, rd_high, rd_low, wr_chan, wr_div, wr_fmt} = 13'h0000;
      {port_latch, port_dir, pin_in} = 18'h00000;
      ext_code = 10'h000;
      err_total = 0;
      checks_done = 0;
      repeat (8) @(posedge clk);
      resetn <= 1'b1;
      @(posedge clk);
      #1;
      chk({done_flag_q, irq_q, result_high_q}, 10'h000);
      chk(busy_q, 1'b0);
      chk(pin_take_q, 6'h01);
      t_timing();
      t_formats();
      t_lock();
      t_irq();
      t_abort();
      t_cont();
      t_stop();
      t_pins();
      close_out();
   end
endmodule
